// *** common/tfc_pkg.sv ***
/*
  Package for the transmit framer with CRC generator: register indices,
  field positions, reset values, CRC presets and polynomials, carrier types.
  Assumes a 32-bit APB slave where byte address = 4 * register index.
*/
`default_nettype none
package tfc_pkg;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_FRAME_CFG = 8'h18;
  localparam logic [7:0] IDX_CRC_CFG   = 8'h19;
  localparam logic [7:0] IDX_TX_DATA   = 8'h20;
  localparam logic [7:0] IDX_TX_CTRL   = 8'h21;
  // Frame config fields
  localparam int FC_START_LSB = 6;
  localparam int FC_LAST_LSB  = 3;
  localparam int FC_FIRST_LSB = 0;
  // Checksum config fields
  localparam int CC_PRESET_LSB = 16;
  localparam int CC_SKIP_BIT   = 6;
  localparam int CC_SEL_LSB    = 3;
  localparam int CC_TYPE_BIT   = 2;
  localparam int CC_INV_BIT    = 1;
  localparam int CC_EN_BIT     = 0;
  // Control and status fields
  localparam int CT_START_BIT = 0;
  localparam int CT_LEN_LSB   = 8;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_FULL_BIT  = 2;
  // Reset values
  localparam logic [7:0]  FRAME_CFG_RST = 8'h00;
  localparam logic [22:0] CRC_CFG_RST   = 23'h00_0000;
  // Checksum presets, polynomials and widths
  localparam logic [2:0]  SEL_USER     = 3'h7;
  localparam logic [15:0] PRESET_0     = 16'h0000;
  localparam logic [15:0] PRESET_1     = 16'h6363;
  localparam logic [15:0] PRESET_2     = 16'hA671;
  localparam logic [15:0] PRESET_3     = 16'hFFFF;
  localparam logic [15:0] PRESET_4     = 16'h0012;
  localparam logic [15:0] PRESET_5     = 16'hE012;
  localparam logic [15:0] CRC16_POLY   = 16'h8408;
  localparam logic [4:0]  CRC5_POLY    = 5'h12;
  localparam logic [4:0]  CRC16_BITS   = 5'h10;
  localparam logic [4:0]  CRC5_BITS    = 5'h05;
  // Timing and sizes
  localparam int BIT_DIV    = 128;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W     = 8;

  typedef struct packed {
    logic [1:0] start_sym;
    logic [2:0] last_bits;
    logic [2:0] first_bits;
  } tfc_frame_cfg_t;

  typedef struct packed {
    logic [15:0] preset;
    logic        skip;
    logic [2:0]  sel;
    logic        crc5;
    logic        inv;
    logic        en;
  } tfc_crc_cfg_t;

  typedef struct packed {
    logic       sym_strobe;
    logic [1:0] sym;
    logic       bit_strobe;
    logic       bit_val;
    logic       active;
  } tfc_tx_out_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SOF  = 2'b01,
    ST_DATA = 2'b11,
    ST_CRC  = 2'b10
  } tfc_state_t;
endpackage
`default_nettype wire

// *** design/tfc_fifo.sv ***
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tfc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  assign empty     = (wr_q == rd_q);
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
    end else if (in_valid && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (out_ready && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** design/tfc_crc.sv ***
/*
  Bit-serial checksum register, 16-bit or 5-bit, reflected, LSB first.
  Assumes init and step never coincide; init wins if they do.
*/
`timescale 1ns/1ps
`default_nettype none
module tfc_crc (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        init,
  input  wire logic [15:0] init_val,
  input  wire logic        crc5,
  input  wire logic        step,
  input  wire logic        din,
  // Result
  output logic [15:0]      crc_q
);
  logic fb16;
  logic fb5;
  assign fb16 = crc_q[0] ^ din;
  assign fb5  = crc_q[0] ^ din;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 16'h0000;
    end else if (init) begin
      crc_q <= init_val;
    end else if (step && crc5) begin
      crc_q <= {11'h000, ({1'b0, crc_q[4:1]}
               ^ (fb5 ? tfc_pkg::CRC5_POLY : 5'h00))}; // RL8
    end else if (step) begin
      crc_q <= {1'b0, crc_q[15:1]}
               ^ (fb16 ? tfc_pkg::CRC16_POLY : 16'h0000); // RL11
    end
  end
endmodule
`default_nettype wire

// *** design/tfc_tx_encoder.sv ***
/*
  Transmit framer: APB registers, byte FIFO, start symbol, trims, checksum.
  Assumes an APB master on pclk; modulator samples tx_o on its strobes.
*/
// Added by the designer: the APB register port.
// Functional notes
// (RL1) Start field picks no start symbol or symbol pattern 0, 1 or 2.
// (RL2) Last-bits field trims the end of the final byte; zero sends all.
// (RL3) First-bits field trims the start of the first byte; zero sends all.
// (RL4) Sixteen-bit user preset is the start value when selector is 111b.
// (RL5) Skip bit leaves the first byte out of the checksum.
// (RL6) Selector picks fixed presets 0000h,6363h,A671h,FFFFh,0012h,E012h.
// (RL7) Five-bit checksum starts from the low byte of the preset only.
// (RL8) Type bit: zero makes a 16-bit checksum, one a 5-bit checksum.
// (RL9) Complement bit sends the checksum inverted.
// (RL10) Enable bit adds the checksum to the frame; off by reset.
// (RL11) 16-bit checksum is CCITT reflected, LSB first, after the data.
// (RL12) Reserved register bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module tfc_tx_encoder #(
  parameter int BIT_DIV    = tfc_pkg::BIT_DIV,
  parameter int FIFO_DEPTH = tfc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Toward the modulator
  output tfc_pkg::tfc_tx_out_t tx_o
);
  tfc_pkg::tfc_frame_cfg_t fcfg_q;
  tfc_pkg::tfc_crc_cfg_t   ccfg_q;
  tfc_pkg::tfc_frame_cfg_t fsnap_q;
  tfc_pkg::tfc_crc_cfg_t   csnap_q;
  tfc_pkg::tfc_state_t     state_q;
  tfc_pkg::tfc_tx_out_t    tx_q;
  logic [31:0] rdata_q;
  logic [7:0]  nbytes_q;
  logic [7:0]  bcnt_q;
  logic [15:0] div_q;
  logic        tick;
  logic        have_q;
  logic        first_act_q;
  logic        last_act_q;
  logic [7:0]  sh_q;
  logic [3:0]  idx_q;
  logic [3:0]  end_q;
  logic [4:0]  cidx_q;
  logic [15:0] crc_val;
  logic        crc_bit;
  logic        setup;
  logic        acc;
  logic        hit_data;
  logic        mapped;
  logic        wr_done;
  logic        go;
  logic        fifo_in_ready;
  logic        fifo_ov;
  logic [7:0]  fifo_od;
  logic        load;
  logic        ld_first;
  logic        ld_last;
  logic        data_tick;
  logic        byte_done;
  logic [4:0]  crc_len;

  function automatic logic idx_is(input logic [11:0] a,
                                  input logic [7:0] idx);
    idx_is = (a[11:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction
  function automatic logic [15:0] preset_of(input tfc_pkg::tfc_crc_cfg_t c);
    logic [15:0] p;
    case (c.sel)
      3'h0: p = tfc_pkg::PRESET_0; // RL6
      3'h1: p = tfc_pkg::PRESET_1;
      3'h2: p = tfc_pkg::PRESET_2;
      3'h3: p = tfc_pkg::PRESET_3;
      3'h4: p = tfc_pkg::PRESET_4;
      3'h5: p = tfc_pkg::PRESET_5;
      tfc_pkg::SEL_USER: p = c.preset; // RL4
      default: p = tfc_pkg::PRESET_0;
    endcase
    // Five-bit mode keeps only the low byte
    preset_of = c.crc5 ? {8'h00, p[7:0]} : p; // RL7
  endfunction

  // APB decode; data writes stall while the FIFO is full
  assign setup    = psel && !penable;
  assign acc      = psel && penable;
  assign hit_data = idx_is(paddr, tfc_pkg::IDX_TX_DATA);
  assign mapped   = idx_is(paddr, tfc_pkg::IDX_FRAME_CFG)
                 || idx_is(paddr, tfc_pkg::IDX_CRC_CFG)
                 || hit_data || idx_is(paddr, tfc_pkg::IDX_TX_CTRL);
  assign pready   = !(acc && pwrite && hit_data) || fifo_in_ready;
  assign pslverr  = acc && !mapped;
  assign prdata   = rdata_q;
  assign wr_done  = acc && pwrite && pready && mapped;
  assign go       = wr_done && idx_is(paddr, tfc_pkg::IDX_TX_CTRL)
                 && pwdata[tfc_pkg::CT_START_BIT]
                 && (state_q == tfc_pkg::ST_IDLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcfg_q <= tfc_pkg::FRAME_CFG_RST;
    end else if (wr_done && idx_is(paddr, tfc_pkg::IDX_FRAME_CFG)) begin
      fcfg_q <= pwdata[7:0]; // RL12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccfg_q <= tfc_pkg::CRC_CFG_RST;
    end else if (wr_done && idx_is(paddr, tfc_pkg::IDX_CRC_CFG)) begin
      ccfg_q <= {pwdata[31:tfc_pkg::CC_PRESET_LSB],
                 pwdata[tfc_pkg::CC_SKIP_BIT],
                 pwdata[tfc_pkg::CC_SEL_LSB+:3],
                 pwdata[tfc_pkg::CC_TYPE_BIT],
                 pwdata[tfc_pkg::CC_INV_BIT],
                 pwdata[tfc_pkg::CC_EN_BIT]}; // RL12
    end
  end

  // Read data captured in the setup cycle, reserved bits zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup) begin
      rdata_q <= 32'h0000_0000;
      if (idx_is(paddr, tfc_pkg::IDX_FRAME_CFG)) begin
        rdata_q[7:0] <= fcfg_q; // RL12
      end
      if (idx_is(paddr, tfc_pkg::IDX_CRC_CFG)) begin
        rdata_q[31:16] <= ccfg_q.preset;
        rdata_q[6:0]   <= {ccfg_q.skip, ccfg_q.sel, ccfg_q.crc5,
                           ccfg_q.inv, ccfg_q.en}; // RL12
      end
      if (idx_is(paddr, tfc_pkg::IDX_TX_CTRL)) begin
        rdata_q[tfc_pkg::CT_LEN_LSB+:8]  <= nbytes_q;
        rdata_q[tfc_pkg::ST_BUSY_BIT]  <= (state_q != tfc_pkg::ST_IDLE);
        rdata_q[tfc_pkg::ST_EMPTY_BIT] <= !fifo_ov;
        rdata_q[tfc_pkg::ST_FULL_BIT]  <= !fifo_in_ready;
      end
    end
  end

  tfc_fifo #(.W(tfc_pkg::BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (acc && pwrite && hit_data),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_ov),
    .out_ready (load),
    .out_data  (fifo_od)
  );

  // Bit-rate enable from the clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(BIT_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == 16'h0000);

  // Byte fetch; FIFO underrun simply stalls the frame
  assign load      = (state_q == tfc_pkg::ST_DATA) && !have_q && fifo_ov
                  && (bcnt_q != nbytes_q);
  assign ld_first  = (bcnt_q == 8'h00);
  assign ld_last   = (bcnt_q == nbytes_q - 8'h01);
  assign data_tick = (state_q == tfc_pkg::ST_DATA) && have_q && tick;
  assign byte_done = data_tick && (idx_q + 4'h1 >= end_q);
  assign crc_len   = csnap_q.crc5 ? tfc_pkg::CRC5_BITS
                                  : tfc_pkg::CRC16_BITS; // RL8
  assign crc_bit   = crc_val[cidx_q[3:0]];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsnap_q  <= tfc_pkg::FRAME_CFG_RST;
      csnap_q  <= tfc_pkg::CRC_CFG_RST;
      nbytes_q <= 8'h00;
    end else if (go) begin
      fsnap_q  <= fcfg_q;
      csnap_q  <= ccfg_q;
      nbytes_q <= pwdata[tfc_pkg::CT_LEN_LSB+:8];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_q      <= 1'b0;
      sh_q        <= 8'h00;
      idx_q       <= 4'h0;
      end_q       <= 4'h8;
      bcnt_q      <= 8'h00;
      first_act_q <= 1'b0;
      last_act_q  <= 1'b0;
    end else if (go) begin
      have_q <= 1'b0;
      bcnt_q <= 8'h00;
    end else if (load) begin
      have_q      <= 1'b1;
      sh_q        <= fifo_od;
      bcnt_q      <= bcnt_q + 8'h01;
      first_act_q <= ld_first;
      last_act_q  <= ld_last;
      idx_q       <= (ld_first && fsnap_q.first_bits != 3'h0)
                   ? 4'h8 - {1'b0, fsnap_q.first_bits} : 4'h0; // RL3
      end_q       <= (ld_last && fsnap_q.last_bits != 3'h0)
                   ? {1'b0, fsnap_q.last_bits} : 4'h8; // RL2
    end else if (byte_done) begin
      have_q <= 1'b0;
    end else if (data_tick) begin
      idx_q <= idx_q + 4'h1;
    end
  end

  tfc_crc u_crc (
    .clk      (pclk),
    .rst_n    (presetn),
    .init     (go),
    .init_val (preset_of(ccfg_q)),
    .crc5     (csnap_q.crc5),
    .step     (data_tick && !(first_act_q && csnap_q.skip)), // RL5
    .din      (sh_q[idx_q[2:0]]),
    .crc_q    (crc_val)
  );

  // Frame sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= tfc_pkg::ST_IDLE;
      cidx_q  <= 5'h00;
    end else begin
      case (state_q)
        tfc_pkg::ST_IDLE: begin
          cidx_q <= 5'h00;
          if (go) begin
            state_q <= tfc_pkg::ST_SOF;
          end
        end
        tfc_pkg::ST_SOF: begin
          if (tick) begin
            state_q <= tfc_pkg::ST_DATA;
          end
        end
        tfc_pkg::ST_DATA: begin
          if ((byte_done && last_act_q) || nbytes_q == 8'h00) begin
            state_q <= csnap_q.en ? tfc_pkg::ST_CRC
                                  : tfc_pkg::ST_IDLE; // RL10
          end
        end
        tfc_pkg::ST_CRC: begin
          if (tick) begin
            cidx_q <= cidx_q + 5'h01;
            if (cidx_q == crc_len - 5'h01) begin
              state_q <= tfc_pkg::ST_IDLE; // RL8
            end
          end
        end
        default: state_q <= tfc_pkg::ST_IDLE;
      endcase
    end
  end

  // Registered outputs toward the modulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_q <= '0;
    end else begin
      tx_q.sym_strobe <= 1'b0;
      tx_q.bit_strobe <= 1'b0;
      tx_q.active     <= (state_q != tfc_pkg::ST_IDLE);
      if (state_q == tfc_pkg::ST_SOF && tick
          && fsnap_q.start_sym != 2'b00) begin
        tx_q.sym_strobe <= 1'b1;
        tx_q.sym        <= fsnap_q.start_sym - 2'b01; // RL1
      end
      if (data_tick) begin
        tx_q.bit_strobe <= 1'b1;
        tx_q.bit_val    <= sh_q[idx_q[2:0]];
      end
      if (state_q == tfc_pkg::ST_CRC && tick) begin
        tx_q.bit_strobe <= 1'b1;
        tx_q.bit_val    <= crc_bit ^ csnap_q.inv; // RL9 RL11
      end
    end
  end
  assign tx_o = tx_q;

  a_sof_pattern: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    tx_q.sym_strobe |-> tx_q.sym == $past(fsnap_q.start_sym) - 2'b01)
    else $error("start symbol pattern mismatch");
  a_sof_none: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (state_q == tfc_pkg::ST_SOF && tick && fsnap_q.start_sym == 2'b00)
    |=> !tx_q.sym_strobe)
    else $error("start symbol sent while disabled");
  a_last_trim: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    (load && ld_last && fsnap_q.last_bits != 3'h0)
    |=> end_q == {1'b0, $past(fsnap_q.last_bits)})
    else $error("last byte length wrong");
  a_first_trim: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    (load && ld_first && fsnap_q.first_bits != 3'h0)
    |=> idx_q == 4'h8 - {1'b0, $past(fsnap_q.first_bits)})
    else $error("first byte start bit wrong");
  a_user_preset: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    (go && ccfg_q.sel == tfc_pkg::SEL_USER && !ccfg_q.crc5)
    |=> crc_val == $past(ccfg_q.preset))
    else $error("user preset not loaded");
  a_skip_first: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    (data_tick && first_act_q && csnap_q.skip) |=> $stable(crc_val))
    else $error("first byte entered checksum");
  a_fix_preset: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    (go && ccfg_q.sel == 3'h2 && !ccfg_q.crc5) |=> crc_val == 16'hA671)
    else $error("fixed preset wrong");
  a_crc5_init: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (go && ccfg_q.crc5) |=> crc_val[15:8] == 8'h00)
    else $error("five-bit preset uses high byte");
  a_crc_width: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    (state_q == tfc_pkg::ST_CRC) |-> cidx_q < crc_len)
    else $error("checksum longer than its type");
  a_crc_invert: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    (state_q == tfc_pkg::ST_CRC && tick)
    |=> tx_q.bit_val == ($past(crc_bit) ^ csnap_q.inv))
    else $error("checksum bit polarity wrong");
  a_crc_off: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    (state_q == tfc_pkg::ST_CRC) |-> csnap_q.en)
    else $error("checksum sent while disabled");
  a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    (setup && idx_is(paddr, tfc_pkg::IDX_FRAME_CFG)) |=> prdata[31:8] == 0)
    else $error("reserved bits read non-zero");
endmodule
`default_nettype wire

// *** verification/tfc_rf_sink.sv ***
/*
  Far-side modulator model: gathers start symbol and bits of each frame.
  Assumes one-cycle strobes on pclk and a frame marked by tx.active.
*/
`timescale 1ns/1ps
`default_nettype none
module tfc_rf_sink (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Encoder output
  input  wire tfc_pkg::tfc_tx_out_t tx,
  // Collected frame
  output logic                      done,
  output logic [299:0]              bits_q,
  output logic [8:0]                cnt_q,
  output logic [2:0]                sym_q
);
  logic act_q;

  // Frame ends when active falls; bench samples before the clear lands
  assign done = act_q & ~tx.active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q  <= 1'b0;
      bits_q <= '0;
      cnt_q  <= '0;
      sym_q  <= '0;
    end else begin
      act_q <= tx.active;
      if (done) begin
        bits_q <= '0;
        cnt_q  <= '0;
        sym_q  <= '0;
      end else begin
        if (tx.bit_strobe) begin
          bits_q[cnt_q] <= tx.bit_val;
          cnt_q         <= cnt_q + 9'h001;
        end
        if (tx.sym_strobe) begin
          sym_q <= {1'b1, tx.sym};
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tfc_tx_encoder_tb.sv ***
/*
  Self-checking bench for the transmit framer: APB master, frame model,
  FIFO fill to refusal. Assumes the sink model collects each frame.
*/
`timescale 1ns/1ps
`default_nettype none
module tfc_tx_encoder_tb;
  typedef struct packed {
    logic [299:0] bits;
    logic [8:0]   cnt;
    logic [2:0]   sym;
  } tfc_exp_t;

  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic                 pready;
  logic                 pslverr;
  logic                 done;
  logic                 err;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic [31:0]          rd;
  logic [299:0]         rx_bits;
  logic [8:0]           rx_cnt;
  logic [2:0]           rx_sym;
  tfc_pkg::tfc_tx_out_t tx;
  tfc_exp_t             exp_q[$];
  tfc_exp_t             e_w;
  int                   failures;
  int                   samples_checked;
  int                   seed;

  // Short bit period keeps frames brief
  tfc_tx_encoder #(.BIT_DIV(4), .FIFO_DEPTH(32)) tfc_tx_encoder_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .tx_o(tx));
  tfc_rf_sink tfc_rf_sink_inst (
    .pclk(pclk), .presetn(presetn), .tx(tx), .done(done),
    .bits_q(rx_bits), .cnt_q(rx_cnt), .sym_q(rx_sym));

  always #10 pclk = ~pclk;

  task close_out();
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task check(input logic [299:0] seen, input logic [299:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t seen %0h want %0h", $time, seen, want);
    end
  endtask

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // Idle edge after each transfer avoids two drives in one step
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20000);
    r  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20000) begin
      failures++;
      close_out();
    end
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] want,
                        input logic ew);
    apb(1'b0, ad(idx), 32'h0000_0000, rd, err);
    check(rd, want);
    check(err, ew);
  endtask

  function automatic logic [15:0] step(input logic [15:0] c,
                                       input logic d, input logic c5);
    logic fb;
    fb = c[0] ^ d;
    c  = c5 ? {12'h000, c[4:1]} : {1'b0, c[15:1]};
    if (fb)
      c = c ^ (c5 ? {11'h000, tfc_pkg::CRC5_POLY} : tfc_pkg::CRC16_POLY);
    return c;
  endfunction

  // Builds the expected frame, then configures, fills and starts
  task automatic frame(input logic [1:0] st, input logic [2:0] n,
                       input logic [2:0] m, input tfc_pkg::tfc_crc_cfg_t c,
                       input int nb);
    tfc_exp_t    e;
    logic [7:0]  b[$];
    logic [15:0] crc;
    logic [7:0]  v;
    int          lo, hi, k, i, w;
    e = '0;
    e.sym = (st == 2'b00) ? 3'b000 : {1'b1, st - 2'b01};
    case (c.sel)
      3'd0: crc = tfc_pkg::PRESET_0;
      3'd1: crc = tfc_pkg::PRESET_1;
      3'd2: crc = tfc_pkg::PRESET_2;
      3'd3: crc = tfc_pkg::PRESET_3;
      3'd4: crc = tfc_pkg::PRESET_4;
      3'd5: crc = tfc_pkg::PRESET_5;
      3'd7: crc = c.preset;
      default: crc = 16'h0000;
    endcase
    if (c.crc5)
      crc = {11'h000, crc[4:0]};
    for (k = 0; k < nb; k++) begin
      v = 8'($random(seed));
      b.push_back(v);
      lo = (k == 0 && n != 0) ? 8 - n : 0;
      hi = (k == nb - 1 && m != 0) ? m - 1 : 7;
      for (i = lo; i <= hi; i++) begin
        e.bits[e.cnt] = v[i];
        e.cnt++;
        if (c.en && !(c.skip && k == 0))
          crc = step(crc, v[i], c.crc5);
      end
    end
    w = c.crc5 ? 5 : 16;
    if (c.inv)
      crc = ~crc;
    for (i = 0; c.en && i < w; i++) begin
      e.bits[e.cnt] = crc[i];
      e.cnt++;
    end
    exp_q.push_back(e);
    apb(1'b1, ad(tfc_pkg::IDX_FRAME_CFG), {24'h0, st, m, n}, rd, err);
    apb(1'b1, ad(tfc_pkg::IDX_CRC_CFG), {c.preset, 9'h000, c[6:0]}, rd, err);
    for (k = 0; k < nb && k < 32; k++)
      apb(1'b1, ad(tfc_pkg::IDX_TX_DATA), {24'h0, b[k]}, rd, err);
    if (nb > 32) begin
      apb(1'b0, ad(tfc_pkg::IDX_TX_CTRL), 32'h0000_0000, rd, err);
      check(rd[2:0], 3'b100);
    end
    apb(1'b1, ad(tfc_pkg::IDX_TX_CTRL), {16'h0, 8'(nb), 8'h01}, rd, err);
    // Bytes past the depth stall until the frame drains one
    for (; k < nb; k++)
      apb(1'b1, ad(tfc_pkg::IDX_TX_DATA), {24'h0, b[k]}, rd, err);
    i = 0;
    do begin
      apb(1'b0, ad(tfc_pkg::IDX_TX_CTRL), 32'h0000_0000, rd, err);
      i++;
    end while (rd[0] !== 1'b0 && i < 5000);
    check(rd[0], 1'b0);
  endtask

  always @(posedge pclk) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(1, 0);
      end else begin
        e_w = exp_q.pop_front();
        check(rx_sym, e_w.sym);
        check(rx_cnt, e_w.cnt);
        check(rx_bits, e_w.bits);
      end
    end
  end

  initial begin
    repeat (90000) @(posedge pclk);
    failures++;
    close_out();
  end

  initial begin
    tfc_pkg::tfc_crc_cfg_t c;
    int                    i;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    failures = 0;
    samples_checked = 0;
    seed = 32'h59ae7dda;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(tfc_pkg::IDX_FRAME_CFG, 32'h0000_0000, 1'b0);
    rd_chk(tfc_pkg::IDX_CRC_CFG, 32'h0000_0000, 1'b0);
    rd_chk(tfc_pkg::IDX_TX_CTRL, 32'h0000_0002, 1'b0);
    apb(1'b1, ad(tfc_pkg::IDX_FRAME_CFG), 32'hFFFF_FFFF, rd, err);
    rd_chk(tfc_pkg::IDX_FRAME_CFG, 32'h0000_00FF, 1'b0);
    apb(1'b1, ad(tfc_pkg::IDX_CRC_CFG), 32'hFFFF_FFFF, rd, err);
    rd_chk(tfc_pkg::IDX_CRC_CFG, 32'hFFFF_007F, 1'b0);
    apb(1'b1, ad(8'h40), 32'hFFFF_FFFF, rd, err);
    check(err, 1'b1);
    rd_chk(8'h40, 32'h0000_0000, 1'b1);
    // Every preset code but 0 (checksum off there), start code, both widths, trims and skip
    for (i = 0; i < 10; i++) begin
      c = '0;
      c.en = (i != 0);
      c.sel = (i == 8) ? 3'd4 : (i == 9) ? 3'd5 : (i >= 6) ? 3'd7 : 3'(i);
      c.crc5 = (i >= 8);
      c.inv = i[0];
      c.skip = (i == 3 || i == 7);
      c.preset = 16'($random(seed));
      frame(i[1:0], 3'(i * 3), 3'(i * 5), c, 2 + i % 3);
    end
    c.sel = 3'd3;
    c.crc5 = 1'b0;
    c.en = 1'b1;
    frame(2'b01, 3'd0, 3'd0, c, 33);
    repeat (5) @(posedge pclk);
    check(exp_q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
